// ### logic/tdcs_axis_detect.sv
// one-axis pulse detector: threshold crossing, time limit, polarity
`timescale 1ns/1ns
module tdcs_axis_detect (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_valid_i,
  input wire logic [7:0] accel_i,
  input wire logic [6:0] threshold_i,
  input wire logic [7:0] time_limit_i,
  output logic start_o,
  output logic end_o,
  output logic negative_o
);
  logic [7:0] magnitude;
  logic above;
  logic active;
  logic [7:0] duration;

  // two's complement magnitude; -128 becomes 128, still fits 8 bits
  always_comb begin
    magnitude = accel_i[7] ? 8'(~accel_i + tdcs_pkg::COUNT_ONE) : accel_i;
    above = magnitude > {1'b0, threshold_i};
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active <= 1'b0;
      duration <= tdcs_pkg::COUNT_ZERO;
      start_o <= 1'b0;
      end_o <= 1'b0;
      negative_o <= 1'b0;
    end else begin
      start_o <= 1'b0;
      end_o <= 1'b0;
      if (sample_valid_i) begin
        if (!active && above) begin
          active <= 1'b1;
          duration <= tdcs_pkg::COUNT_ZERO;
          negative_o <= accel_i[7];
          start_o <= 1'b1;
        end else if (active && !above) begin
          active <= 1'b0;
          // too long a crossing is not a tap
          end_o <= duration <= time_limit_i;
        end else if (active && duration != tdcs_pkg::COUNT_MAX) begin
          duration <= duration + tdcs_pkg::COUNT_ONE;
        end
      end
    end
  end
endmodule

// ### logic/tdcs_pkg.sv
// constants for the tap detection configuration and status registers
package tdcs_pkg;
  localparam int unsigned AXES = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned THR_W = 7;
  localparam logic [7:0] ADDR_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_SOURCE = 8'h22;
  localparam logic [7:0] ADDR_THR_X = 8'h23;
  localparam logic [7:0] ADDR_THR_Y = 8'h24;
  localparam logic [7:0] ADDR_THR_Z = 8'h25;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [6:0] THR_RESET = 7'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // tap_config fields
  localparam int unsigned CFG_ABORT_BIT = 7;
  localparam int unsigned CFG_LATCH_BIT = 6;
  // tap_source fields
  localparam int unsigned SRC_ACTIVE_BIT = 7;
  localparam int unsigned SRC_DOUBLE_BIT = 3;
  // axis index: 0 x, 1 y, 2 z
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LATENCY = 2'h1,
    ST_WINDOW = 2'h3
  } tdcs_state_t;
endpackage

// ### logic/tdcs_top.sv
// tap detection configuration, status and detection sequencing
// Operation
// - abort off: latency pulses keep double detection
// - abort on: short latency pulse cancels double
// - latch on holds flags until source read
// - six enables: z,y,x double/single bits 5..0
// - config register resets to zero
// - report only enabled axis and event type
// - status bit 7 flags event active
// - status bits 6..4 flag z,y,x events
// - status bit 3: single 0, double 1
// - status bits 2..0: z,y,x polarity, 1 negative
// - latched: freeze detail bits until source read
// - source read clears bits and interrupt
// - separate threshold per axis starts detection
// - threshold: 7 bits, bit 7 zero, resets zero
// - z threshold uses the same layout
// - threshold codes unsigned, 0.063 g steps
// - pulses during latency interval only feed the abort check
`timescale 1ns/1ns
module tdcs_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic [7:0] accel_x_i,
  input wire logic [7:0] accel_y_i,
  input wire logic [7:0] accel_z_i,
  input wire logic [7:0] time_limit_i,
  input wire logic [7:0] latency_i,
  input wire logic [7:0] window_i,
  output logic tap_irq_o
);
  logic [7:0] tap_config;
  logic [6:0] threshold [tdcs_pkg::AXES];
  logic event_active;
  logic [2:0] axis_event;
  logic double_tap_flag;
  logic [2:0] polarity;
  logic [7:0] accel [tdcs_pkg::AXES];
  logic [2:0] pulse_start;
  logic [2:0] pulse_end;
  logic [2:0] pulse_negative;
  tdcs_pkg::tdcs_state_t state;
  tdcs_pkg::tdcs_state_t next_state;
  logic [7:0] interval_count;
  logic [2:0] first_axis;
  logic latency_start_seen;
  logic double_tap_abort;
  logic event_latch_enable;
  logic [2:0] single_enable;
  logic [2:0] double_enable;
  logic [2:0] single_hit;
  logic [2:0] double_hit;
  logic [2:0] first_hit;
  logic latency_done;
  logic window_done;
  logic abort_now;
  logic evt_fire;
  logic [2:0] evt_axis;
  logic evt_double;
  logic source_read;
  logic frozen;

  // bit pair per axis: odd bit double, even bit single
  function automatic logic [2:0] enables(input logic [7:0] cfg,
                                         input logic dbl);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < tdcs_pkg::AXES; i++) begin
      res[i] = cfg[2 * i + int'(dbl)];
    end
    return res;
  endfunction

  function automatic logic is_threshold(input logic [7:0] addr);
    return addr >= tdcs_pkg::ADDR_THR_X && addr <= tdcs_pkg::ADDR_THR_Z;
  endfunction

  function automatic logic [1:0] threshold_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - tdcs_pkg::ADDR_THR_X;
    return diff[1:0];
  endfunction

  always_comb begin
    accel[0] = accel_x_i;
    accel[1] = accel_y_i;
    accel[2] = accel_z_i;
  end

  // the same detector per axis, each with its own threshold
  for (genvar g = 0; g < tdcs_pkg::AXES; g++) begin : g_axis
    tdcs_axis_detect u_detect (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .sample_valid_i(sample_valid_i),
      .accel_i(accel[g]),
      .threshold_i(threshold[g]),
      .time_limit_i(time_limit_i),
      .start_o(pulse_start[g]),
      .end_o(pulse_end[g]),
      .negative_o(pulse_negative[g])
    );
  end

  always_comb begin
    double_tap_abort = tap_config[tdcs_pkg::CFG_ABORT_BIT];
    event_latch_enable = tap_config[tdcs_pkg::CFG_LATCH_BIT];
    single_enable = enables(tap_config, 1'b0);
    double_enable = enables(tap_config, 1'b1);
    source_read = reg_rd_i && reg_addr_i == tdcs_pkg::ADDR_SOURCE;
  end

  // configuration register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tap_config <= tdcs_pkg::CONFIG_RESET;
    end else if (reg_wr_i && reg_addr_i == tdcs_pkg::ADDR_CONFIG) begin
      tap_config <= reg_wdata_i;
    end
  end

  // threshold registers; bit 7 is not stored and reads zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < tdcs_pkg::AXES; i++) begin
        threshold[i] <= tdcs_pkg::THR_RESET;
      end
    end else if (reg_wr_i && is_threshold(reg_addr_i)) begin
      threshold[threshold_index(reg_addr_i)] <= reg_wdata_i[6:0];
    end
  end

  // detection sequencing
  always_comb begin
    single_hit = 3'h0;
    double_hit = 3'h0;
    first_hit = 3'h0;
    abort_now = 1'b0;
    latency_done = sample_valid_i && interval_count >= latency_i;
    window_done = sample_valid_i && interval_count >= window_i;
    next_state = state;
    case (state)
      tdcs_pkg::ST_IDLE: begin
        first_hit = pulse_end & (single_enable | double_enable);
        single_hit = pulse_end & single_enable;
        if (first_hit != 3'h0) begin
          next_state = tdcs_pkg::ST_LATENCY;
        end
      end
      tdcs_pkg::ST_LATENCY: begin
        // a pulse that both starts and ends inside the interval aborts
        abort_now = double_tap_abort && (latency_start_seen ||
                    pulse_start != 3'h0) && pulse_end != 3'h0;
        if (abort_now) begin
          next_state = tdcs_pkg::ST_IDLE;
        end else if (latency_done) begin
          // without abort the sequence goes on to the window if a first axis has double enabled, else back to idle
          if ((first_axis & double_enable) != 3'h0) begin
            next_state = tdcs_pkg::ST_WINDOW;
          end else begin
            next_state = tdcs_pkg::ST_IDLE;
          end
        end
      end
      tdcs_pkg::ST_WINDOW: begin
        double_hit = pulse_end & first_axis & double_enable;
        if (double_hit != 3'h0 || window_done) begin
          next_state = tdcs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = tdcs_pkg::ST_IDLE;
      end
    endcase
    evt_double = double_hit != 3'h0;
    evt_axis = evt_double ? double_hit : single_hit;
    evt_fire = evt_axis != 3'h0;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= tdcs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one counter serves latency and window, restarted at each change
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      interval_count <= tdcs_pkg::COUNT_ZERO;
    end else if (next_state != state) begin
      interval_count <= tdcs_pkg::COUNT_ZERO;
    end else if (sample_valid_i && interval_count != tdcs_pkg::COUNT_MAX) begin
      interval_count <= interval_count + tdcs_pkg::COUNT_ONE;
    end
  end

  // pulses inside the latency interval only feed the abort check
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_axis <= 3'h0;
      latency_start_seen <= 1'b0;
    end else if (state == tdcs_pkg::ST_IDLE) begin
      first_axis <= first_hit;
      latency_start_seen <= 1'b0;
    end else if (state == tdcs_pkg::ST_LATENCY &&
                 pulse_start != 3'h0) begin
      latency_start_seen <= 1'b1;
    end
  end

  // source register: an event in the read cycle wins over the clear
  always_comb begin
    frozen = event_latch_enable && event_active;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      event_active <= 1'b0;
      axis_event <= 3'h0;
      double_tap_flag <= 1'b0;
      polarity <= 3'h0;
    end else if (evt_fire && (!frozen || source_read)) begin
      event_active <= 1'b1;
      axis_event <= evt_axis;
      double_tap_flag <= evt_double;
      polarity <= evt_axis & pulse_negative;
    end else if (source_read) begin
      event_active <= 1'b0;
      axis_event <= 3'h0;
      double_tap_flag <= 1'b0;
      polarity <= 3'h0;
    end
  end

  always_comb begin
    tap_irq_o = event_active;
  end

  // read data is registered and shows the value before any clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= tdcs_pkg::READ_ZERO;
    end else if (reg_rd_i) begin
      if (reg_addr_i == tdcs_pkg::ADDR_CONFIG) begin
        reg_rdata_o <= tap_config;
      end else if (reg_addr_i == tdcs_pkg::ADDR_SOURCE) begin
        reg_rdata_o <= {event_active, axis_event[2], axis_event[1],
                        axis_event[0], double_tap_flag, polarity};
      end else if (is_threshold(reg_addr_i)) begin
        reg_rdata_o <= {1'b0, threshold[threshold_index(reg_addr_i)]};
      end else begin
        reg_rdata_o <= tdcs_pkg::READ_ZERO;
      end
    end
  end
endmodule

// ### tb/tdcs_assertions.sv
// port checker for the tap register bank
`timescale 1ns/1ns
module tdcs_assertions (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic tap_irq_o
);
  logic [7:0] cfg;
  logic cfg_wr;
  logic rd_src;
  assign rd_src = reg_rd_i && reg_addr_i == 8'h22;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg <= 8'h00;
      cfg_wr <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 8'h21) begin
      cfg <= reg_wdata_i;
      cfg_wr <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_cfg_rw;
    reg_wr_i && reg_addr_i == 8'h21 ##1 reg_rd_i && reg_addr_i == 8'h21
    |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_cfg_rw: assert property (p_cfg_rw)
    else $error("config readback wrong");
  property p_cfg_reset;
    reg_rd_i && reg_addr_i == 8'h21 && !cfg_wr |=> reg_rdata_o == 8'h00;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config not zero after reset");
  property p_thr_rw;
    reg_wr_i && reg_addr_i inside {[8'h23:8'h25]} ##1
    reg_rd_i && reg_addr_i == $past(reg_addr_i)
    |=> reg_rdata_o == {1'b0, $past(reg_wdata_i[6:0], 2)};
  endproperty
  a_thr_rw: assert property (p_thr_rw)
    else $error("threshold readback wrong");
  property p_thr_msb;
    reg_rd_i && reg_addr_i inside {[8'h23:8'h25]} |=> !reg_rdata_o[7];
  endproperty
  a_thr_msb: assert property (p_thr_msb)
    else $error("threshold top bit set");
  property p_clear;
    rd_src && !$past(sample_valid_i) && !$past(sample_valid_i, 2)
    |=> !tap_irq_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("source read left interrupt");
  property p_ea;
    rd_src |=> reg_rdata_o[7] == $past(tap_irq_o);
  endproperty
  a_ea: assert property (p_ea)
    else $error("active flag differs from interrupt");
  property p_cause;
    $rose(tap_irq_o) |-> $past(sample_valid_i, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("interrupt without sample");
  property p_enable;
    $rose(tap_irq_o) |-> cfg[5:0] != 6'h00;
  endproperty
  a_enable: assert property (p_enable)
    else $error("interrupt with no enable");
  property p_latch;
    tap_irq_o && cfg[6] && !rd_src |=> tap_irq_o;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched event lost");
  property p_src_wr;
    reg_wr_i && reg_addr_i == 8'h22 && !tap_irq_o &&
    !$past(sample_valid_i) && !$past(sample_valid_i, 2) |=> !tap_irq_o;
  endproperty
  a_src_wr: assert property (p_src_wr)
    else $error("source write raised flag");
  c_irq: cover property ($rose(tap_irq_o));
  c_read: cover property (rd_src && tap_irq_o);
  c_cfg: cover property (reg_wr_i && reg_addr_i == 8'h21);
endmodule
bind tdcs_top tdcs_assertions i_tdcs_assertions (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
  .tap_irq_o(tap_irq_o));

// ### tb/tdcs_host_model.sv
// host side of the register strobe port
`timescale 1ns/1ns
module tdcs_host_model (
  input wire logic sys_clk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // launched on the falling edge so the design samples settled values
  task xfer(input logic w, input logic r, input logic [7:0] a, d);
    @(negedge sys_clk_i);
    reg_wr_o = w;
    reg_rd_o = r;
    reg_addr_o = a;
    reg_wdata_o = d;
  endtask
  // released lines show inverted values so stale data cannot match
  task idle;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule

// ### tb/tdcs_top_tb_top.sv
// testbench top for the tap register bank
`timescale 1ns/1ns
module tdcs_top_tb_top;
  logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, sample_valid_i, tap_irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, ax, ay, az, lat;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000877E;
  int fail_count = 0;
  int checked = 0;
  logic rd_q = 1'b0;
  tdcs_host_model i_tdcs_host_model (.sys_clk_i(sys_clk_i),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i));
  tdcs_top i_tdcs_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sample_valid_i(sample_valid_i), .accel_x_i(ax), .accel_y_i(ay),
    .accel_z_i(az), .time_limit_i(8'h04), .latency_i(lat),
    .window_i(8'h08), .tap_irq_o(tap_irq_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task check(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_tdcs_host_model.xfer(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_tdcs_host_model.xfer(1'b0, 1'b1, a, 8'h00);
    i_tdcs_host_model.idle();
  endtask
  task smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(negedge sys_clk_i);
    ax = x;
    ay = y;
    az = z;
    sample_valid_i = 1'b1;
    @(negedge sys_clk_i);
    sample_valid_i = 1'b0;
  endtask
  // quiet samples after each pulse let the latency count run
  task tap(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    smp(x, y, z);
    repeat (3) smp(8'h00, 8'h00, 8'h00);
  endtask
  task scen(input logic [7:0] c, x1, y1, z1, x2, y2, z2, e);
    wr(8'h21, c);
    rd(8'h21, c);
    tap(x1, y1, z1);
    tap(x2, y2, z2);
    check("irq", {7'h00, tap_irq_o}, {7'h00, e[7]});
    rd(8'h22, e);
    rd(8'h22, 8'h00);
    check("irq", {7'h00, tap_irq_o}, 8'h00);
  endtask
  // three x taps; the second starts and ends inside the latency interval
  task scen3(input logic [7:0] c, e);
    wr(8'h21, c);
    rd(8'h21, c);
    repeat (3) tap(8'h14, 8'h00, 8'h00);
    check("irq", {7'h00, tap_irq_o}, {7'h00, e[7]});
    rd(8'h22, e);
    rd(8'h22, 8'h00);
  endtask
  // result lands on the edge that takes the read strobe and is checked one edge later
  always @(posedge sys_clk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q) begin
      #1;
      check("rdata", reg_rdata_o, exp_q.pop_front());
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    {ax, ay, az, lat} = 32'h00000000;
    sample_valid_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i) sys_rst_i = 1'b0;
    for (logic [7:0] a = 8'h20; a < 8'h26; a++)
      rd(a, 8'h00);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      wr(8'h21, seed[7:0]);
      rd(8'h21, seed[7:0]);
      wr(8'h23 + i[7:0], seed[15:8] | 8'h80);
      rd(8'h23 + i[7:0], {1'b0, seed[14:8]});
      wr(8'h23 + i[7:0], 8'h0A);
      rd(8'h23 + i[7:0], 8'h0A);
    end
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h00);
    scen(8'h41, 8'h14, 0, 0, 0, 0, 0, 8'h90);
    scen(8'h04, 0, 8'hEC, 0, 0, 0, 0, 8'hA2);
    scen(8'h40, 8'h14, 0, 0, 0, 0, 0, 8'h00);
    scen(8'h51, 8'h14, 0, 0, 0, 0, 8'h14, 8'h90);
    lat = 8'h02;
    scen(8'h42, 8'h14, 0, 0, 8'h14, 0, 0, 8'h98);
    lat = 8'h04;
    scen3(8'h42, 8'h98);
    scen3(8'hC2, 8'h00);
    // the last read result is compared one edge after the task returns
    repeat (2) @(posedge sys_clk_i);
    if (exp_q.size() != 0) begin
      fail_count++;
    end
    finish_test();
  end
  initial begin
    #(100 * 4000);
    fail_count++;
    finish_test();
  end
endmodule
